// file: src/rcp_rx_port.sv
`timescale 1ns/1ps
// Summary of operation
// - Negated output enable leaves the data bus undriven in cell and packet mode.
// - Output enable sampled low pops the queue head onto the bus at that link edge.
// - Cell mode marks the first word of each cell on the start pin.
// - Packet mode marks the first word of each packet on the start pin.
// - Chunk mode pulses the start pin only with each chunk's first word.
// - Chunk mode shows packet starts on the separate frame start output.
// - Odd parity of each driven word, or of its low byte when the wide bit is clear, appears with that word.
// - Parity stays low in clear-channel and HDLC modes.
// - Packet mode raises end while a packet's last word is driven.
// - Packet mode valid is high only when bus and flags carry real data.
// - Cell mode samples the port select bus each link edge and compares.
// - Cell available is driven only on address match with enable, else undriven.
// - Packet available is driven only on address match with enable, else undriven.
// - The 16-bit bus carries cell data or packet data by mode.
// - Cell available is high while the queue holds a whole cell.
// - Availability is driven from the link cycle after a matching address.
// - Packet mode error pulses with the last word of a bad packet.
// - Modulus is low for two valid bytes, high for upper byte only.
module rcp_rx_port
	import rcp_pkg::*;
(
	input  wire logic                             CORE_CLK_IN,
	input  wire logic                             RST_IN,
	input  wire logic [rcp_pkg::RCP_ADDR_W-1:0]   AV_ADDRESS_IN,
	input  wire logic                             AV_READ_IN,
	input  wire logic                             AV_WRITE_IN,
	input  wire logic [31:0]                      AV_WRITEDATA_IN,
	input  wire logic [3:0]                       AV_BYTEENABLE_IN,
	output logic      [31:0]                      AV_READDATA_OUT,
	output logic                                  AV_WAITREQUEST_OUT,
	input  wire logic                             RX_IF_CLOCK_IN,
	input  wire logic                             RX_OUT_ENABLE_N_IN,
	input  wire logic                             RX_ENABLE_N_ALT_IN,
	input  wire logic [rcp_pkg::RCP_SEL_W-1:0]    RX_PORT_SEL_IN,
	output logic      [rcp_pkg::RCP_DATA_W-1:0]   RX_BUS_OUT,
	output logic                                  RX_BUS_OE_OUT,
	output logic                                  RX_START_OUT,
	output logic                                  RX_FRAME_START_OUT,
	output logic                                  RX_PARITY_OUT,
	output logic                                  RX_PKT_END_OUT,
	output logic                                  RX_PKT_VALID_OUT,
	output logic                                  RX_PKT_ERROR_OUT,
	output logic                                  RX_PKT_MODULUS_OUT,
	output logic                                  RX_AVAILABLE_OUT,
	output logic                                  RX_AVAILABLE_OE_OUT,
	input  wire logic [rcp_pkg::RCP_DATA_W-1:0]   QUEUE_DATA_IN,
	input  wire logic                             QUEUE_VALID_IN,
	input  wire logic                             QUEUE_SOP_IN,
	input  wire logic                             QUEUE_EOP_IN,
	input  wire logic                             QUEUE_ERR_IN,
	input  wire logic                             QUEUE_MOD_IN,
	input  wire logic                             QUEUE_CELL_READY_IN,
	input  wire logic                             QUEUE_PKT_READY_IN,
	output logic                                  QUEUE_POP_OUT
);
	import rcp_pkg::*;

	typedef struct packed {
		logic                  ack;
		logic                  wait_req;
		logic [31:0]           rdata;
		logic [RCP_REG_W-1:0]  pkt_ctrl0;
		logic [RCP_REG_W-1:0]  cell_addr;
		logic [RCP_REG_W-1:0]  cell_num;
		logic [RCP_REG_W-1:0]  mode_cfg;
		logic [RCP_REG_W-1:0]  chunk_len;
		logic                  clk_prev;
		logic                  match;
		logic [RCP_DATA_W-1:0] bus;
		logic                  bus_oe;
		logic                  start;
		logic                  frame_start;
		logic                  parity;
		logic                  pkt_end;
		logic                  pkt_valid;
		logic                  pkt_err;
		logic                  pkt_mod;
		logic                  avail;
		logic                  avail_oe;
		logic                  pop;
		logic [RCP_REG_W-1:0]  chunk_cnt;
		logic                  err_seen;
	} rcp_state_s;

	rcp_state_s st_q;
	rcp_state_s st_d;

	logic                 clk_s;
	logic                 oe_n_s;
	logic                 enb_n_s;
	logic [RCP_SEL_W-1:0] sel_s;

	// Every port pin crosses two flops before use
	rcp_sync #(
		.WIDTH (3 + RCP_SEL_W)
	) u_sync (
		.clk_in   (CORE_CLK_IN),
		.rst_in   (RST_IN),
		.async_in ({RX_IF_CLOCK_IN, RX_OUT_ENABLE_N_IN, RX_ENABLE_N_ALT_IN, RX_PORT_SEL_IN}),
		.sync_out ({clk_s, oe_n_s, enb_n_s, sel_s})
	);

	// Word-aligned index, or all ones for a misaligned address
	function automatic logic [RCP_IDX_W-1:0] reg_index(input logic [RCP_ADDR_W-1:0] addr);
		if (addr[1:0] != 2'h0) begin
			return '1;
		end else begin
			return addr[RCP_ADDR_W-1:2];
		end
	endfunction

	function automatic logic odd_parity(input logic [RCP_DATA_W-1:0] word, input logic wide);
		if (wide) begin
			return ~(^word);
		end else begin
			return ~(^word[7:0]);
		end
	endfunction

	logic                 link_edge;
	logic                 port_mode;
	logic                 pkt_mode;
	logic                 chunk_mode;
	logic                 wide;
	logic [RCP_IDX_W-1:0] idx;
	logic [RCP_SEL_W-1:0] my_addr;
	logic                 fill_ok;
	logic                 take;
	logic [31:0]          status;

	always_comb begin
		st_d       = st_q;
		link_edge  = clk_s & ~st_q.clk_prev;
		port_mode  = (st_q.mode_cfg[1:0] == RCP_MODE_CELL) ||
		             (st_q.mode_cfg[1:0] == RCP_MODE_PKT);
		pkt_mode   = st_q.mode_cfg[1:0] == RCP_MODE_PKT;
		chunk_mode = pkt_mode & st_q.pkt_ctrl0[RCP_CTRL0_CHUNK_BIT];
		wide       = st_q.pkt_ctrl0[RCP_CTRL0_WIDE_BIT];
		idx        = reg_index(AV_ADDRESS_IN);
		take       = link_edge & port_mode & ~oe_n_s & QUEUE_VALID_IN;
		status     = '0;
		status[RCP_ST_MATCH_BIT]                 = st_q.match;
		status[RCP_ST_AVAIL_BIT]                 = st_q.avail;
		status[RCP_ST_OE_BIT]                    = st_q.bus_oe;
		status[RCP_ST_ERR_BIT]                   = st_q.err_seen;
		status[RCP_ST_MODE_LSB+1:RCP_ST_MODE_LSB] = st_q.mode_cfg[1:0];

		if (pkt_mode) begin
			my_addr = st_q.pkt_ctrl0[RCP_SEL_W-1:0];
		end else begin
			my_addr = st_q.cell_addr[RCP_SEL_W-1:0];
		end
		fill_ok = pkt_mode ? QUEUE_PKT_READY_IN : QUEUE_CELL_READY_IN;

		// Bus slave: waitrequest drops one cycle after a request is seen
		st_d.ack      = (AV_READ_IN | AV_WRITE_IN) & ~st_q.ack;
		st_d.wait_req = ~st_d.ack;
		if (AV_READ_IN && !st_q.ack) begin
			if (idx == RCP_IDX_PKT_CTRL0) begin
				st_d.rdata = {24'h000000, st_q.pkt_ctrl0};
			end else if (idx == RCP_IDX_CELL_ADDR) begin
				st_d.rdata = {24'h000000, st_q.cell_addr};
			end else if (idx == RCP_IDX_CELL_NUM) begin
				st_d.rdata = {24'h000000, st_q.cell_num};
			end else if (idx == RCP_IDX_MODE) begin
				st_d.rdata = {24'h000000, st_q.mode_cfg};
			end else if (idx == RCP_IDX_CHUNK_LEN) begin
				st_d.rdata = {24'h000000, st_q.chunk_len};
			end else if (idx == RCP_IDX_STATUS) begin
				st_d.rdata = status;
			end else begin
				st_d.rdata = 32'h00000000;
			end
		end
		if (AV_WRITE_IN && st_q.ack && AV_BYTEENABLE_IN[0]) begin
			if (idx == RCP_IDX_PKT_CTRL0) begin
				st_d.pkt_ctrl0 = AV_WRITEDATA_IN[7:0];
			end else if (idx == RCP_IDX_CELL_ADDR) begin
				st_d.cell_addr = AV_WRITEDATA_IN[7:0];
			end else if (idx == RCP_IDX_CELL_NUM) begin
				st_d.cell_num = AV_WRITEDATA_IN[7:0];
			end else if (idx == RCP_IDX_MODE) begin
				st_d.mode_cfg = AV_WRITEDATA_IN[7:0];
			end else if (idx == RCP_IDX_CHUNK_LEN) begin
				st_d.chunk_len = AV_WRITEDATA_IN[7:0];
			end else if (idx == RCP_IDX_STATUS) begin
				// Writing status clears the sticky error seen bit
				st_d.err_seen = 1'b0;
			end
		end

		st_d.clk_prev = clk_s;
		st_d.pop      = 1'b0;

		// All link-side pins change only on a detected link rising edge
		if (link_edge) begin
			if (!port_mode) begin
				// Port idle in clear-channel and HDLC modes
				st_d.bus_oe      = 1'b0;
				st_d.avail_oe    = 1'b0;
				st_d.match       = 1'b0;
				st_d.start       = 1'b0;
				st_d.frame_start = 1'b0;
				st_d.parity      = 1'b0;
				st_d.pkt_end     = 1'b0;
				st_d.pkt_valid   = 1'b0;
				st_d.pkt_err     = 1'b0;
				st_d.pkt_mod     = 1'b0;
			end else begin
				st_d.bus_oe = ~oe_n_s;
				// Select bus compared each edge, single-PHY ties it low
				st_d.match = (sel_s == my_addr) & ~enb_n_s;
				// Driven in the same cycle as the match is registered, else released
				st_d.avail_oe = st_d.match;
				st_d.avail    = st_d.match & fill_ok;
				if (take) begin
					// Head word popped and driven now
					st_d.pop    = 1'b1;
					st_d.bus    = QUEUE_DATA_IN;
					st_d.parity = odd_parity(QUEUE_DATA_IN, wide);
					if (chunk_mode) begin
						// Chunk start on shared pin, packet start on frame pin
						st_d.start       = QUEUE_SOP_IN || (st_q.chunk_cnt == 8'h00);
						st_d.frame_start = QUEUE_SOP_IN;
						if (QUEUE_SOP_IN || QUEUE_EOP_IN ||
						    st_q.chunk_cnt + 8'h01 >= st_q.chunk_len) begin
							st_d.chunk_cnt = QUEUE_SOP_IN && !QUEUE_EOP_IN ? 8'h01 : 8'h00;
						end else begin
							st_d.chunk_cnt = st_q.chunk_cnt + 8'h01;
						end
					end else begin
						st_d.start       = QUEUE_SOP_IN;
						st_d.frame_start = 1'b0;
					end
					if (pkt_mode) begin
						st_d.pkt_end   = QUEUE_EOP_IN;
						st_d.pkt_err   = QUEUE_EOP_IN & QUEUE_ERR_IN;
						st_d.pkt_mod   = QUEUE_EOP_IN & QUEUE_MOD_IN & wide;
						st_d.pkt_valid = 1'b1;
						if (QUEUE_EOP_IN && QUEUE_ERR_IN) begin
							st_d.err_seen = 1'b1;
						end
					end else begin
						st_d.pkt_end   = 1'b0;
						st_d.pkt_err   = 1'b0;
						st_d.pkt_mod   = 1'b0;
						st_d.pkt_valid = 1'b0;
					end
				end else begin
					// No word this edge: flags drop, bus holds last word
					st_d.start       = 1'b0;
					st_d.frame_start = 1'b0;
					st_d.pkt_end     = 1'b0;
					st_d.pkt_err     = 1'b0;
					st_d.pkt_mod     = 1'b0;
					st_d.pkt_valid   = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			st_q           <= '0;
			st_q.wait_req  <= 1'b1;
			st_q.pkt_ctrl0 <= RCP_RST_PKT_CTRL0;
			st_q.cell_addr <= RCP_RST_CELL_ADDR;
			st_q.cell_num  <= RCP_RST_CELL_NUM;
			st_q.mode_cfg  <= RCP_RST_MODE;
			st_q.chunk_len <= RCP_RST_CHUNK_LEN;
		end else begin
			st_q <= st_d;
		end
	end

	assign AV_READDATA_OUT     = st_q.rdata;
	assign AV_WAITREQUEST_OUT  = st_q.wait_req;
	assign RX_BUS_OUT          = st_q.bus;
	assign RX_BUS_OE_OUT       = st_q.bus_oe;
	assign RX_START_OUT        = st_q.start;
	assign RX_FRAME_START_OUT  = st_q.frame_start;
	assign RX_PARITY_OUT       = st_q.parity;
	assign RX_PKT_END_OUT      = st_q.pkt_end;
	assign RX_PKT_VALID_OUT    = st_q.pkt_valid;
	assign RX_PKT_ERROR_OUT    = st_q.pkt_err;
	assign RX_PKT_MODULUS_OUT  = st_q.pkt_mod;
	assign RX_AVAILABLE_OUT    = st_q.avail;
	assign RX_AVAILABLE_OE_OUT = st_q.avail_oe;
	assign QUEUE_POP_OUT       = st_q.pop;
endmodule

// file: src/rcp_pkg.sv
package rcp_pkg;

	typedef enum logic [1:0] {
		RCP_MODE_CELL  = 2'b00,
		RCP_MODE_PKT   = 2'b01,
		RCP_MODE_CLEAR = 2'b10,
		RCP_MODE_HDLC  = 2'b11
	} rcp_mode_e;

	localparam int unsigned RCP_ADDR_W    = 13;
	localparam int unsigned RCP_IDX_W     = 11;
	localparam int unsigned RCP_DATA_W    = 16;
	localparam int unsigned RCP_SEL_W     = 5;
	localparam int unsigned RCP_REG_W     = 8;

	// Register indices; byte address is four times the index
	localparam logic [RCP_IDX_W-1:0] RCP_IDX_PKT_CTRL0   = 11'h502;
	localparam logic [RCP_IDX_W-1:0] RCP_IDX_CELL_ADDR   = 11'h513;
	localparam logic [RCP_IDX_W-1:0] RCP_IDX_CELL_NUM    = 11'h517;
	localparam logic [RCP_IDX_W-1:0] RCP_IDX_MODE        = 11'h520;
	localparam logic [RCP_IDX_W-1:0] RCP_IDX_CHUNK_LEN   = 11'h521;
	localparam logic [RCP_IDX_W-1:0] RCP_IDX_STATUS      = 11'h522;

	// Reset values
	localparam logic [RCP_REG_W-1:0] RCP_RST_PKT_CTRL0   = 8'h00;
	localparam logic [RCP_REG_W-1:0] RCP_RST_CELL_ADDR   = 8'h00;
	localparam logic [RCP_REG_W-1:0] RCP_RST_CELL_NUM    = 8'h00;
	localparam logic [RCP_REG_W-1:0] RCP_RST_MODE        = 8'h00;
	localparam logic [RCP_REG_W-1:0] RCP_RST_CHUNK_LEN   = 8'h08;

	// Field positions
	localparam int unsigned RCP_CTRL0_CHUNK_BIT = 5;
	localparam int unsigned RCP_CTRL0_WIDE_BIT  = 6;
	localparam int unsigned RCP_ST_MATCH_BIT    = 0;
	localparam int unsigned RCP_ST_AVAIL_BIT    = 1;
	localparam int unsigned RCP_ST_OE_BIT       = 2;
	localparam int unsigned RCP_ST_ERR_BIT      = 3;
	localparam int unsigned RCP_ST_MODE_LSB     = 4;

	localparam int unsigned RCP_SYNC_STAGES = 2;

endpackage

// file: src/rcp_sync.sv
`timescale 1ns/1ps
module rcp_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stable_q;

	// First stage is read only by the second stage
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_q   <= '0;
			stable_q <= '0;
		end else begin
			meta_q   <= async_in;
			stable_q <= meta_q;
		end
	end

	assign sync_out = stable_q;
endmodule

// file: test/rcp_rx_port_monitor.sv
`timescale 1ns/1ps
module rcp_rx_port_monitor (
	input wire logic        CORE_CLK_IN,
	input wire logic        RST_IN,
	input wire logic [15:0] RX_BUS_OUT,
	input wire logic        RX_BUS_OE_OUT,
	input wire logic        RX_START_OUT,
	input wire logic        RX_PARITY_OUT,
	input wire logic        RX_PKT_END_OUT,
	input wire logic        RX_PKT_VALID_OUT,
	input wire logic        RX_PKT_ERROR_OUT,
	input wire logic        RX_PKT_MODULUS_OUT,
	input wire logic [15:0] QUEUE_DATA_IN,
	input wire logic        QUEUE_EOP_IN,
	input wire logic        QUEUE_POP_OUT
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);
	property p_pop_word; QUEUE_POP_OUT |-> RX_BUS_OE_OUT && RX_BUS_OUT == $past(QUEUE_DATA_IN); endproperty
	a_pop_word: assert property (p_pop_word) else $error("popped word not on bus");
	// One pop per link period, so eight quiet cycles is a safe floor
	property p_pop_gap; QUEUE_POP_OUT |=> !QUEUE_POP_OUT [*8]; endproperty
	a_pop_gap: assert property (p_pop_gap) else $error("pops too close");
	property p_bus_hold; $changed(RX_BUS_OUT) |-> QUEUE_POP_OUT; endproperty
	a_bus_hold: assert property (p_bus_hold) else $error("bus moved without pop");
	property p_parity; QUEUE_POP_OUT |-> RX_PARITY_OUT == ~^RX_BUS_OUT || RX_PARITY_OUT == ~^RX_BUS_OUT[7:0]; endproperty
	a_parity: assert property (p_parity) else $error("parity not odd");
	property p_start_new; $rose(RX_START_OUT) |-> QUEUE_POP_OUT; endproperty
	a_start_new: assert property (p_start_new) else $error("start without new word");
	property p_end_last; $rose(RX_PKT_END_OUT) |-> QUEUE_POP_OUT && $past(QUEUE_EOP_IN); endproperty
	a_end_last: assert property (p_end_last) else $error("end not on last word");
	property p_err_end; RX_PKT_ERROR_OUT |-> RX_PKT_END_OUT; endproperty
	a_err_end: assert property (p_err_end) else $error("error away from end");
	property p_mod_end; RX_PKT_MODULUS_OUT |-> RX_PKT_END_OUT && RX_PKT_VALID_OUT; endproperty
	a_mod_end: assert property (p_mod_end) else $error("modulus away from end");
	property p_valid_oe; RX_PKT_VALID_OUT |-> RX_BUS_OE_OUT; endproperty
	a_valid_oe: assert property (p_valid_oe) else $error("valid with bus undriven");
endmodule
bind rcp_rx_port rcp_rx_port_monitor u_mon (.CORE_CLK_IN, .RST_IN, .RX_BUS_OUT, .RX_BUS_OE_OUT,
	.RX_START_OUT, .RX_PARITY_OUT, .RX_PKT_END_OUT, .RX_PKT_VALID_OUT, .RX_PKT_ERROR_OUT,
	.RX_PKT_MODULUS_OUT, .QUEUE_DATA_IN, .QUEUE_EOP_IN, .QUEUE_POP_OUT);

// file: test/rcp_far_end.sv
`timescale 1ns/1ps
module rcp_far_end (
	input  wire logic       cmd_oe_n_in,
	input  wire logic       cmd_enb_n_in,
	input  wire logic [4:0] cmd_sel_in,
	output logic            link_clk_out,
	output logic            oe_n_out,
	output logic            enb_n_out,
	output logic [4:0]      sel_out
);
	initial begin
		link_clk_out = 1'b0;
		oe_n_out = 1'b1;
		enb_n_out = 1'b1;
		sel_out = 5'h00;
	end
	always #62.5 link_clk_out = ~link_clk_out;
	// Hold after the edge so the synchronised copy never races the clock
	always @(posedge link_clk_out) begin
		oe_n_out <= #20 cmd_oe_n_in;
		enb_n_out <= #20 cmd_enb_n_in;
		sel_out <= #20 cmd_sel_in;
	end
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
	import rcp_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [12:0] av_addr = 13'h0;
	logic        av_rd = 1'b0;
	logic        av_wr = 1'b0;
	logic [31:0] av_wd = 32'h0;
	logic [31:0] av_rdata, rd;
	logic        av_wait, lclk, oe_n, enb_n, c_oe_n = 1'b1, c_enb_n = 1'b1;
	logic [4:0]  sel, c_sel = 5'h00;
	logic [15:0] bus;
	logic        bus_oe, start, fstart, par, pend, pval, perr, pmod, avl, avl_oe, pop;
	logic        rdy = 1'b0;
	int          hd = 0;
	int          errors = 0;
	int          checked = 0;
	// Row: data, sop, eop, err, mod, chunk start for chunks of two words
	logic [20:0] rows [6] = '{{16'h1234, 5'h11}, {16'hffff, 5'h00}, {16'h0001, 5'h0d},
		{16'hab00, 5'h11}, {16'h8000, 5'h0a}, {16'h0f0f, 5'h19}};
	logic [20:0] head;
	logic [10:0] ri [5] = '{RCP_IDX_PKT_CTRL0, RCP_IDX_CELL_ADDR, RCP_IDX_CELL_NUM,
		RCP_IDX_MODE, RCP_IDX_CHUNK_LEN};
	logic [7:0]  rv [5] = '{RCP_RST_PKT_CTRL0, RCP_RST_CELL_ADDR, RCP_RST_CELL_NUM,
		RCP_RST_MODE, RCP_RST_CHUNK_LEN};
	assign head = rows[hd % 6];
	always #2 clk = ~clk;
	always @(posedge clk) if (pop && hd < 6) hd <= hd + 1;
	rcp_rx_port u_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .AV_ADDRESS_IN(av_addr),
		.AV_READ_IN(av_rd), .AV_WRITE_IN(av_wr), .AV_WRITEDATA_IN(av_wd),
		.AV_BYTEENABLE_IN(4'hf), .AV_READDATA_OUT(av_rdata), .AV_WAITREQUEST_OUT(av_wait),
		.RX_IF_CLOCK_IN(lclk), .RX_OUT_ENABLE_N_IN(oe_n), .RX_ENABLE_N_ALT_IN(enb_n),
		.RX_PORT_SEL_IN(sel), .RX_BUS_OUT(bus), .RX_BUS_OE_OUT(bus_oe), .RX_START_OUT(start),
		.RX_FRAME_START_OUT(fstart), .RX_PARITY_OUT(par), .RX_PKT_END_OUT(pend),
		.RX_PKT_VALID_OUT(pval), .RX_PKT_ERROR_OUT(perr), .RX_PKT_MODULUS_OUT(pmod),
		.RX_AVAILABLE_OUT(avl), .RX_AVAILABLE_OE_OUT(avl_oe), .QUEUE_DATA_IN(head[20:5]),
		.QUEUE_VALID_IN(hd < 6), .QUEUE_SOP_IN(head[4]), .QUEUE_EOP_IN(head[3]),
		.QUEUE_ERR_IN(head[2]), .QUEUE_MOD_IN(head[1]), .QUEUE_CELL_READY_IN(rdy),
		.QUEUE_PKT_READY_IN(rdy), .QUEUE_POP_OUT(pop));
	rcp_far_end u_far (.cmd_oe_n_in(c_oe_n), .cmd_enb_n_in(c_enb_n), .cmd_sel_in(c_sel),
		.link_clk_out(lclk), .oe_n_out(oe_n), .enb_n_out(enb_n), .sel_out(sel));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task av(input logic wr, input logic [10:0] idx, input logic [7:0] wd);
		@(posedge clk);
		av_addr <= {idx, 2'b00};
		av_rd <= !wr;
		av_wr <= wr;
		av_wd <= {24'h0, wd};
		// Only the watchdog ends a wait that never finishes
		do begin
			@(posedge clk);
		end while (av_wait !== 1'b0);
		rd = av_rdata;
		av_rd <= 1'b0;
		av_wr <= 1'b0;
	endtask
	task avail(input logic [4:0] s, input logic enb, input logic r, input logic exp_oe);
		@(negedge lclk);
		c_sel <= s;
		c_enb_n <= enb;
		@(posedge clk) rdy <= r;
		// Driven from the link cycle after the address is seen
		repeat (2) @(negedge lclk);
		chk(avl_oe, exp_oe);
		if (exp_oe) chk(avl, r);
	endtask
	task stream(input logic pkt, input logic chunk);
		logic [20:0] r;
		@(negedge lclk);
		hd <= 0;
		c_oe_n <= 1'b0;
		for (int i = 0; i <= 6; i++) begin
			@(negedge lclk);
			if (i == 5) c_oe_n <= 1'b1;
			if (i > 0) begin
				r = rows[i-1];
				chk({bus_oe, bus}, {1'b1, r[20:5]});
				chk(par, ~^r[20:5]);
				chk(start, chunk ? r[0] : r[4]);
				chk(fstart, chunk & r[4]);
				chk({pend, perr, pmod, pval}, pkt ? {r[3:1], 1'b1} : 4'h0);
			end
		end
		@(negedge lclk);
		chk(bus_oe, 1'b0);
	endtask
	task give_verdict;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		give_verdict;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({av_wait, bus_oe, avl_oe, pop}, 4'h8);
		for (int k = 0; k < 5; k++) begin
			av(1'b0, ri[k], 8'h00);
			chk(rd, {24'h0, rv[k]});
		end
		av(1'b1, 11'h600, 8'hff);
		av(1'b0, 11'h600, 8'h00);
		chk(rd, 32'h0);
		av(1'b1, RCP_IDX_CELL_NUM, 8'h5a);
		av(1'b1, RCP_IDX_CELL_ADDR, 8'h0b);
		av(1'b1, RCP_IDX_PKT_CTRL0, 8'h4b);
		av(1'b0, RCP_IDX_CELL_NUM, 8'h00);
		chk(rd, 32'h5a);
		avail(5'h0b, 1'b0, 1'b1, 1'b1);
		avail(5'h0b, 1'b0, 1'b0, 1'b1);
		avail(5'h0c, 1'b0, 1'b1, 1'b0);
		avail(5'h0b, 1'b1, 1'b1, 1'b0);
		stream(1'b0, 1'b0);
		av(1'b1, RCP_IDX_MODE, 8'h01);
		avail(5'h0b, 1'b0, 1'b1, 1'b1);
		avail(5'h0a, 1'b0, 1'b1, 1'b0);
		stream(1'b1, 1'b0);
		// Bad packet end leaves the sticky error bit and packet mode in status
		av(1'b0, RCP_IDX_STATUS, 8'h00);
		chk(rd[5:3], 3'b011);
		av(1'b1, RCP_IDX_STATUS, 8'h00);
		av(1'b0, RCP_IDX_STATUS, 8'h00);
		chk(rd[3], 1'b0);
		// Queue left empty: bus may stay driven but nothing is valid
		c_oe_n <= 1'b0;
		repeat (3) @(negedge lclk);
		chk({pval, pend}, 2'b00);
		c_oe_n <= 1'b1;
		av(1'b1, RCP_IDX_CHUNK_LEN, 8'h02);
		av(1'b1, RCP_IDX_PKT_CTRL0, 8'h6b);
		stream(1'b1, 1'b1);
		for (int m = 2; m < 4; m++) begin
			av(1'b1, RCP_IDX_MODE, m[7:0]);
			c_oe_n <= 1'b0;
			repeat (3) @(negedge lclk);
			chk({par, bus_oe, avl_oe}, 3'b000);
		end
		give_verdict;
	end
endmodule
